// File: rtl/tsp_cfg.svh
`ifndef TSP_CFG_SVH
`define TSP_CFG_SVH
// Packet size limit reset value, in characters
`define TSP_SIZE_LIMIT_RST     8'h80
// Inter-character limit reset value, in hundredths of a second
`define TSP_TIME_LIMIT_RST     16'h0064
// Tick length in ns (one hundredth of a second) and clock period in ns
`define TSP_TICK_NS            10000000
`define TSP_CLK_NS             20
`define TSP_TICK_CYCLES        (`TSP_TICK_NS / `TSP_CLK_NS)
// Carriage return and the top of the control character range
`define TSP_CHAR_CR            8'h0D
`define TSP_CTRL_MAX           8'h1F
// Route reset value: zero hops means no route
`define TSP_ROUTE_LEN_RST      3'h0
// Options register bit positions set by the two-wire mode
`define TSP_OPT_TWO_WIRE_LO    7
`define TSP_OPT_TWO_WIRE_HI    8
`endif

// File: rtl/tsp_pkg.sv
package tsp_pkg;
    typedef enum logic [1:0] {
        TSP_DIRECT_LINK_DRIVE,
        TSP_FOUR_WIRE,
        TSP_HALF_DUPLEX,
        TSP_TWO_WIRE
    } tsp_drive_type;
    typedef enum logic [1:0] {
        TSP_CLOSE_NONE,
        TSP_CLOSE_CTRL,
        TSP_CLOSE_SIZE,
        TSP_CLOSE_TIME
    } tsp_close_type;
endpackage

// File: rtl/tsp_skid_buf.sv
`timescale 1ns/100ps
`default_nettype none
// Two-entry buffer: the source may push while the sink stalls without loss
module tsp_skid_buf #(
    parameter int WIDTH = 10
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    logic [WIDTH-1:0] mem_reg [2];
    logic             rd_ptr_reg;
    logic             wr_ptr_reg;
    logic [1:0]       count_reg;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data  = mem_reg[rd_ptr_reg];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_ptr_reg <= 1'b0;
            wr_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            if (push) begin
                mem_reg[wr_ptr_reg] <= in_data;
                wr_ptr_reg          <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    chk_no_overfill: assert property (@(posedge clk) disable iff (!rst_n)
        count_reg == 2'h2 && !pop |=> count_reg == 2'h2)
        else $error("buffer lost or gained a word while full");
endmodule
`default_nettype wire

// File: rtl/tsp_packetizer.sv
// Functional notes
// - Both modes identical except RTS usage
// - Received characters are gathered into network packets
// - Close packet on CR, size, timeout; CR closes only with the control character setting on
// - Size limit one sends each character
// - Size limit resets to 128 characters
// - Idle limit in hundredths, default 100
// - Packets carry the port's target route
// - Route replaceable at run time by message
// - Route defaults to none
// - Control character setting ends packets, default on
// - Echo setting returns characters, default off
// - Direct link drive keeps drivers always on
// - Four wire tristates drivers without CTS
// - Half duplex disables receiver while transmitting
// - Two wire drives on CTS, mutes receiver while driving
// - Two wire sets options bits 7, 8
// - Driver modes ignored on port zero
`timescale 1ns/100ps
`default_nettype none
`include "tsp_cfg.svh"
module tsp_packetizer #(
    parameter int DATA_W      = 8,
    parameter int SIZE_W      = 8,
    parameter int ROUTE_W     = 32,
    parameter int TICK_CYCLES = `TSP_TICK_CYCLES,
    parameter bit PORT_ZERO   = 1'b0,
    parameter bit HAS_RS485   = 1'b1
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // Static configuration, loaded while cfg_load is high
    input  wire logic                cfg_load,
    input  wire logic                cfg_share_mode,
    input  wire logic [SIZE_W-1:0]   cfg_size_limit,
    input  wire logic [15:0]         cfg_time_limit,
    input  wire logic                cfg_ctrl_char,
    input  wire logic                cfg_echo,
    input  wire tsp_pkg::tsp_drive_type cfg_drive,
    // Route write: static or from a network write message
    input  wire logic                route_wr,
    input  wire logic [2:0]          route_wr_len,
    input  wire logic [ROUTE_W-1:0]  route_wr_data,
    // Received characters from the serial receiver
    input  wire logic                rx_valid,
    input  wire logic [DATA_W-1:0]   rx_data,
    // Modem lines
    input  wire logic                cts,
    input  wire logic                tx_busy,
    output logic                     rts,
    // Driver and receiver gating
    output logic                     tx_drv_en,
    output logic                     rx_en,
    // Echo path to the serial transmitter
    output logic                     echo_valid,
    output logic [DATA_W-1:0]        echo_data,
    // Packet byte stream towards the network
    output logic                     pkt_valid,
    input  wire logic                pkt_ready,
    output logic [DATA_W-1:0]        pkt_data,
    output logic                     pkt_last,
    output logic [2:0]               pkt_route_len,
    output logic [ROUTE_W-1:0]       pkt_route,
    // Status
    output logic [15:0]              options,
    output logic                     rx_overrun,
    output tsp_pkg::tsp_close_type   last_close
);
    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    logic                   share_reg;
    logic [SIZE_W-1:0]      size_reg;
    logic [15:0]            time_reg;
    logic                   ctrl_reg;
    logic                   echo_reg;
    tsp_pkg::tsp_drive_type drive_reg;
    logic [2:0]             route_len_reg;
    logic [ROUTE_W-1:0]     route_reg;

    // Boards without switchable drivers only honour direct link drive
    wire drive_ok = !PORT_ZERO && HAS_RS485;
    wire tsp_pkg::tsp_drive_type drive_sel =
        drive_ok ? cfg_drive : tsp_pkg::TSP_DIRECT_LINK_DRIVE;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            share_reg <= 1'b0;
            size_reg  <= `TSP_SIZE_LIMIT_RST;
            time_reg  <= `TSP_TIME_LIMIT_RST;
            ctrl_reg  <= 1'b1;
            echo_reg  <= 1'b0;
            drive_reg <= tsp_pkg::TSP_DIRECT_LINK_DRIVE;
        end else if (cfg_load) begin
            share_reg <= cfg_share_mode;
            size_reg  <= cfg_size_limit;
            time_reg  <= cfg_time_limit;
            ctrl_reg  <= cfg_ctrl_char;
            echo_reg  <= cfg_echo;
            drive_reg <= drive_sel;
        end
    end

    // Route may change at run time; the new route applies at once, also to a packet in flight
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            route_len_reg <= `TSP_ROUTE_LEN_RST;
            route_reg     <= '0;
        end else if (route_wr) begin
            route_len_reg <= route_wr_len;
            route_reg     <= route_wr_data;
        end
    end

    // ****************************************************************
    // Line driver and receiver gating
    // ****************************************************************
    wire mode_two  = (drive_reg == tsp_pkg::TSP_TWO_WIRE);
    wire mode_four = (drive_reg == tsp_pkg::TSP_FOUR_WIRE);
    wire mode_half = (drive_reg == tsp_pkg::TSP_HALF_DUPLEX);
    assign tx_drv_en = (mode_four || mode_two) ? cts : 1'b1;
    assign rx_en     = mode_half ? !tx_busy :
                       mode_two  ? !tx_drv_en : 1'b1;
    always_comb begin
        options = 16'h0000;
        options[`TSP_OPT_TWO_WIRE_LO] = mode_two;
        options[`TSP_OPT_TWO_WIRE_HI] = mode_two;
    end

    // ****************************************************************
    // Character intake and packet assembly
    // ****************************************************************
    wire char_in  = rx_valid && rx_en;
    wire is_ctrl  = (rx_data <= `TSP_CTRL_MAX);
    wire is_cr    = (rx_data == `TSP_CHAR_CR);
    // With the setting off, CR is stored and only size or time close
    wire term     = ctrl_reg && (is_cr || is_ctrl);

    logic [SIZE_W-1:0] count_reg;
    logic [15:0]       idle_reg;
    logic [31:0]       tick_cnt_reg;
    logic              rx_overrun_reg;
    tsp_pkg::tsp_close_type close_reg;
    logic              echo_v_reg;
    logic [DATA_W-1:0] echo_d_reg;

    wire tick     = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
    wire [SIZE_W-1:0] count_inc = count_reg + SIZE_W'(1);
    // Reaching the limit closes now; a limit of one sends every character
    wire size_hit = (count_inc >= size_reg);
    wire time_hit = (count_reg != '0) && tick && (idle_reg + 16'h0001 >= time_reg);

    logic buf_in_ready;
    logic buf_in_valid;
    logic [DATA_W:0] buf_in_data;
    logic tout_pend_reg;

    // Restraint holds RTS off while the buffer is full; push-to-talk keys it
    assign rts = share_reg ? tx_busy : buf_in_ready;

    // The timeout marker goes ahead of any later character (one stored in the timeout cycle itself cancels the timeout), so an old
    // timeout never closes the next packet; a character that arrives
    // while the marker still waits for room is refused
    wire push_char = char_in && buf_in_ready && !tout_pend_reg;
    wire push_mark = (time_hit || tout_pend_reg) && buf_in_ready && !push_char;
    wire close_now = push_char && (term || size_hit);
    assign buf_in_valid = push_char || push_mark;
    // Timeout closes by an empty marker word with the last flag
    assign buf_in_data  = push_char ? {close_now, rx_data} : {1'b1, {DATA_W{1'b0}}};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg      <= '0;
            idle_reg       <= 16'h0000;
            tick_cnt_reg   <= 32'h0000_0000;
            rx_overrun_reg <= 1'b0;
            close_reg      <= tsp_pkg::TSP_CLOSE_NONE;
            tout_pend_reg  <= 1'b0;
        end else begin
            if (char_in || count_reg == '0 || tick) begin
                tick_cnt_reg <= 32'h0000_0000;
            end else begin
                tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
            end
            if (push_char) begin
                idle_reg  <= 16'h0000;
                count_reg <= close_now ? '0 : count_inc;
                if (close_now) begin
                    close_reg <= term ? tsp_pkg::TSP_CLOSE_CTRL : tsp_pkg::TSP_CLOSE_SIZE;
                end
            end else if (time_hit) begin
                idle_reg      <= 16'h0000;
                count_reg     <= '0;
                tout_pend_reg <= !buf_in_ready;
                close_reg     <= tsp_pkg::TSP_CLOSE_TIME;
            end else if (tick && count_reg != '0) begin
                idle_reg <= idle_reg + 16'h0001;
            end
            if (tout_pend_reg && buf_in_ready) begin
                tout_pend_reg <= 1'b0;
            end
            // Sticky until reset: a character lost to a full buffer or a waiting timeout marker
            if (char_in && !push_char) begin
                rx_overrun_reg <= 1'b1;
            end
        end
    end
    assign rx_overrun = rx_overrun_reg;
    assign last_close = close_reg;

    // ****************************************************************
    // Echo and output buffer
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            echo_v_reg <= 1'b0;
            echo_d_reg <= '0;
        end else begin
            echo_v_reg <= char_in && echo_reg;
            echo_d_reg <= rx_data;
        end
    end
    assign echo_valid = echo_v_reg;
    assign echo_data  = echo_d_reg;

    logic [DATA_W:0] buf_out_data;
    tsp_skid_buf #(.WIDTH(DATA_W + 1)) u_buf (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in_data),
        .out_valid (pkt_valid),
        .out_ready (pkt_ready),
        .out_data  (buf_out_data)
    );
    assign pkt_data      = buf_out_data[DATA_W-1:0];
    assign pkt_last      = buf_out_data[DATA_W];
    assign pkt_route_len = route_len_reg;
    assign pkt_route     = route_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_size_close: assert property (@(posedge clk) disable iff (!rst_n)
        push_char && size_reg == SIZE_W'(1) |-> buf_in_data[DATA_W])
        else $error("size limit one did not close packet");
    chk_cr_close: assert property (@(posedge clk) disable iff (!rst_n)
        push_char && ctrl_reg && rx_data == `TSP_CHAR_CR |=> count_reg == '0)
        else $error("carriage return did not close packet");
    chk_ctrl_off: assert property (@(posedge clk) disable iff (!rst_n)
        push_char && !ctrl_reg && !size_hit |-> !buf_in_data[DATA_W])
        else $error("control character closed packet with setting off");
    chk_echo_data: assert property (@(posedge clk) disable iff (!rst_n)
        char_in && echo_reg |=> echo_valid && echo_data == $past(rx_data))
        else $error("echo missing");
    chk_no_echo: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(echo_reg) |-> !echo_valid)
        else $error("echo with setting off");
    chk_four_wire: assert property (@(posedge clk) disable iff (!rst_n)
        mode_four && !cts |-> !tx_drv_en)
        else $error("four wire drove without cts");
    chk_two_wire: assert property (@(posedge clk) disable iff (!rst_n)
        mode_two |-> !(tx_drv_en && rx_en) && options[8:7] == 2'h3)
        else $error("two wire gating wrong");
    chk_half_rx: assert property (@(posedge clk) disable iff (!rst_n)
        mode_half && tx_busy |-> !rx_en && tx_drv_en)
        else $error("half duplex receiver on while sending");
    chk_direct: assert property (@(posedge clk) disable iff (!rst_n)
        drive_reg == tsp_pkg::TSP_DIRECT_LINK_DRIVE |-> tx_drv_en && rx_en)
        else $error("direct link drive gated");
    chk_idle_empty: assert property (@(posedge clk) disable iff (!rst_n)
        count_reg == '0 |=> tick_cnt_reg == 32'h0000_0000)
        else $error("idle timer ran on empty packet");
    chk_port_zero: assert property (@(posedge clk) disable iff (!rst_n)
        !drive_ok |-> drive_reg == tsp_pkg::TSP_DIRECT_LINK_DRIVE)
        else $error("switched driver mode on fixed port");
endmodule
`default_nettype wire

// File: verif/tsp_term_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Attached terminal: sends chars, keeps echoes
// ****************************************
module tsp_term_model (
    // Clock
    input  wire logic       clk,
    // Characters into the port
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    // Echo from the port
    input  wire logic       echo_valid,
    input  wire logic [7:0] echo_data
);
    logic [7:0] echo_q[$];
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
    end
    // Idle data is the inverse of the last char, so a stale value never matches
    task automatic send(input logic [7:0] c);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_data  <= c;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_data  <= ~c;
    endtask
    always @(posedge clk) begin
        if (echo_valid === 1'b1) begin
            echo_q.push_back(echo_data);
        end
    end
endmodule
`default_nettype wire

// File: verif/transparent_serial_packetizer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module transparent_serial_packetizer_tb;
    localparam int TICK = 10;
    logic clk = 1'b0, rst_n = 1'b0, cfg_load = 1'b0, cfg_share_mode = 1'b0;
    logic cfg_ctrl_char = 1'b1, cfg_echo = 1'b0, route_wr = 1'b0, cts = 1'b1;
    logic tx_busy = 1'b0, pkt_ready = 1'b1, stall_en = 1'b0, hold = 1'b0;
    logic [7:0] cfg_size_limit = 8'h80;
    logic [15:0] cfg_time_limit = 16'h0064;
    logic [2:0] route_wr_len = 3'h0;
    logic [31:0] route_wr_data = 32'h0;
    tsp_pkg::tsp_drive_type cfg_drive = tsp_pkg::TSP_DIRECT_LINK_DRIVE;
    logic rx_valid, rts, tx_drv_en, rx_en, echo_valid, pkt_valid, pkt_last, rx_overrun;
    logic [7:0] rx_data, echo_data, pkt_data;
    logic [2:0] pkt_route_len;
    logic [31:0] pkt_route;
    logic [15:0] options;
    tsp_pkg::tsp_close_type last_close;
    logic [8:0] exp_q[$], got_q[$];
    logic [7:0] echo_exp[$];
    logic [7:0] c;
    logic [34:0] rt;
    logic [3:0] g;
    int err_total = 0, tests_run = 0, cnt = 0, cur_size = 128, cur_time = 100;
    logic cur_ctrl = 1'b1, cur_echo = 1'b0;

    always #10 clk = ~clk;

    tsp_term_model term (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
        .echo_valid(echo_valid), .echo_data(echo_data));

    tsp_packetizer #(.TICK_CYCLES(TICK)) dut (.clk(clk), .rst_n(rst_n), .cfg_load(cfg_load),
        .cfg_share_mode(cfg_share_mode), .cfg_size_limit(cfg_size_limit),
        .cfg_time_limit(cfg_time_limit), .cfg_ctrl_char(cfg_ctrl_char), .cfg_echo(cfg_echo),
        .cfg_drive(cfg_drive), .route_wr(route_wr), .route_wr_len(route_wr_len),
        .route_wr_data(route_wr_data), .rx_valid(rx_valid), .rx_data(rx_data), .cts(cts),
        .tx_busy(tx_busy), .rts(rts), .tx_drv_en(tx_drv_en), .rx_en(rx_en),
        .echo_valid(echo_valid), .echo_data(echo_data), .pkt_valid(pkt_valid),
        .pkt_ready(pkt_ready), .pkt_data(pkt_data), .pkt_last(pkt_last),
        .pkt_route_len(pkt_route_len), .pkt_route(pkt_route), .options(options),
        .rx_overrun(rx_overrun), .last_close(last_close));

    // ****************************************
    // Packet sink with optional random stalls
    // ****************************************
    always @(posedge clk) begin
        pkt_ready <= hold ? 1'b0 : (stall_en ? 1'($urandom) : 1'b1);
        if (pkt_valid === 1'b1 && pkt_ready === 1'b1) begin
            got_q.push_back({pkt_last, pkt_data});
        end
    end

    // ****************************************
    // Checks and expectations
    // ****************************************
    task automatic cmp_bit(input logic gv, input logic ev);
        tests_run++;
        if (gv !== ev) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, gv, ev);
        end
    endtask
    task automatic cmp_vec(input logic [47:0] gv, input logic [47:0] ev);
        tests_run++;
        if (gv !== ev) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, gv, ev);
        end
    endtask
    task automatic give_verdict();
        $display("mismatches %0d, comparisons %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    function automatic logic closes(input logic [7:0] ch, input int n);
        return (cur_ctrl && ch <= 8'h1F) || n >= cur_size;
    endfunction
    function automatic logic [3:0] exp_gate(input int d, input logic ct, input logic bz);
        case (d)
            1: return {ct, 1'b1, 2'b00};
            2: return {1'b1, ~bz, 2'b00};
            3: return {ct, ~ct, 2'b11};
            default: return {1'b1, 1'b1, 2'b00};
        endcase
    endfunction
    task automatic set_cfg(input logic sh, input int sz, input int tm, input logic ct,
                           input logic ec, input int d);
        @(posedge clk);
        cfg_load <= 1'b1;
        cfg_share_mode <= sh;
        cfg_size_limit <= 8'(sz);
        cfg_time_limit <= 16'(tm);
        cfg_ctrl_char <= ct;
        cfg_echo <= ec;
        cfg_drive <= tsp_pkg::tsp_drive_type'(d[1:0]);
        {cur_size, cur_time, cur_ctrl, cur_echo} = {sz, tm, ct, ec};
        @(posedge clk);
        cfg_load <= 1'b0;
    endtask
    task automatic feed(input logic [7:0] ch, input int gap);
        term.send(ch);
        cnt++;
        exp_q.push_back({closes(ch, cnt), ch});
        if (closes(ch, cnt)) begin
            cnt = 0;
        end
        if (cur_echo) begin
            echo_exp.push_back(ch);
        end
        repeat (gap) @(posedge clk);
    endtask
    // A held partial packet ends in a timeout marker word
    task automatic settle();
        if (cnt > 0) begin
            exp_q.push_back(9'h100);
            cnt = 0;
        end
        repeat (cur_time * TICK + 30) @(posedge clk);
        cmp_vec(got_q.size(), exp_q.size());
        while (exp_q.size() > 0 && got_q.size() > 0) begin
            cmp_vec(got_q.pop_front(), exp_q.pop_front());
        end
        cmp_vec(term.echo_q.size(), echo_exp.size());
        while (echo_exp.size() > 0 && term.echo_q.size() > 0) begin
            cmp_vec(term.echo_q.pop_front(), echo_exp.pop_front());
        end
        exp_q.delete();
        got_q.delete();
        echo_exp.delete();
        term.echo_q.delete();
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        give_verdict();
    end

    initial begin
        void'($urandom(32'h2382ec79));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        cmp_vec({tx_drv_en, rx_en, options[8:7]}, 4'hC);
        cmp_vec(pkt_route_len, 3'h0);
        cmp_bit(rts, 1'b1);
        // Defaults: size 128, ctrl on, echo off, 100 hundredths idle
        feed(8'h41, 0);
        feed(8'h42, 0);
        feed(8'h0D, 0);
        feed(8'h5A, 0);
        repeat (100 * TICK - 60) @(posedge clk);
        cmp_vec(got_q.size(), 4);
        settle();
        cmp_vec(last_close, tsp_pkg::TSP_CLOSE_TIME);
        for (int i = 0; i < 4; i++) begin
            set_cfg(1'b0, i[0] ? 4 : 1, 3, i[1], 1'b1, 0);
            for (int j = 0; j < 10; j++) begin
                c = (j == 2) ? 8'h0D : 8'(32 + $urandom % 95);
                feed(c, $urandom % 3);
            end
            settle();
        end
        stall_en = 1'b1;
        set_cfg(1'b1, 2 + $urandom % 5, 3, 1'b1, 1'b0, 0);
        for (int j = 0; j < 20; j++) begin
            feed(8'($urandom % 128), 10);
            cmp_bit(rts, tx_busy);
        end
        settle();
        stall_en = 1'b0;
        // Stalled packet sink: third char is refused
        set_cfg(1'b0, 128, 3, 1'b1, 1'b0, 0);
        hold = 1'b1;
        feed(8'h61, 0);
        feed(8'h62, 0);
        term.send(8'h63);
        repeat (2) @(posedge clk);
        cmp_bit(rx_overrun, 1'b1);
        cmp_bit(rts, 1'b0);
        hold = 1'b0;
        settle();
        for (int i = 0; i < 3; i++) begin
            rt = {3'(1 + $urandom % 7), 32'($urandom)};
            @(posedge clk);
            {route_wr, route_wr_len, route_wr_data} <= {1'b1, rt};
            @(posedge clk);
            route_wr <= 1'b0;
            repeat (2) @(posedge clk);
            cmp_vec({pkt_route_len, pkt_route}, rt);
        end
        for (int d = 0; d < 4; d++) begin
            set_cfg(1'b0, 128, 3, 1'b1, 1'b0, d);
            for (int k = 0; k < 4; k++) begin
                cts <= k[0];
                tx_busy <= k[1];
                @(posedge clk);
                #1;
                g = exp_gate(d, k[0], k[1]);
                cmp_vec({tx_drv_en, rx_en, options[8:7]}, g);
            end
        end
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        cmp_vec(pkt_route_len, 3'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
